// file: tmr2_defs.vh
// Register offsets, field positions, reset values and timing counts for the timer
`ifndef TMR2_DEFS_VH
`define TMR2_DEFS_VH
`define TMR2_ADDR_CONTROL     8'hc8
`define TMR2_ADDR_RELOAD_LOW  8'hca
`define TMR2_RST_CONTROL      8'h00
`define TMR2_RST_RELOAD_LOW   8'h00
`define TMR2_BIT_HIGH_FLAG    7
`define TMR2_BIT_LOW_FLAG     6
`define TMR2_BIT_LOW_IRQ_EN   5
`define TMR2_BIT_CAPTURE_EN   4
`define TMR2_BIT_SPLIT        3
`define TMR2_BIT_RUN          2
`define TMR2_SEL_MSB          1
`define TMR2_SEL_LSB          0
`define TMR2_CORE_CLOCK_DIV       4'd12
`define TMR2_RTC_DIV          3'd7
`define TMR2_SEL_RTC_CLOCK    2'h3
`endif

// file: tmr2_control.v
// Timer control, reload-low register and 16/8-bit auto-reload counting
`timescale 1ns/1ps
`include "tmr2_defs.vh"

module tmr2_control (
  input  wire       i_sys_clk,
  input  wire       i_rst,
  input  wire [7:0] i_sfr_addr,
  input  wire [7:0] i_sfr_wdata,
  input  wire       i_sfr_wr,
  output reg  [7:0] o_sfr_rdata,
  input  wire       i_timer_irq_enable,
  input  wire       i_high_byte_core_clock_select,
  input  wire       i_low_byte_core_clock_select,
  input  wire [7:0] i_reload_high_byte,
  input  wire       i_rtc_clk,
  input  wire       i_comparator0,
  output reg  [7:0] o_count_low_byte,
  output reg  [7:0] o_count_high_byte,
  output reg        o_capture_load,
  output reg  [7:0] o_capture_high_byte,
  output wire       o_timer_irq
);

  reg  [7:0] control_reg;
  reg  [7:0] reload_low_reg;
  reg  [7:0] reload_low_next;
  reg  [7:0] low_count_next;
  reg  [7:0] high_count_next;
  reg  [7:0] control_next;

  wire high_flag = control_reg[`TMR2_BIT_HIGH_FLAG];
  wire low_flag  = control_reg[`TMR2_BIT_LOW_FLAG];
  wire low_irqen = control_reg[`TMR2_BIT_LOW_IRQ_EN];
  wire capture   = control_reg[`TMR2_BIT_CAPTURE_EN];
  wire split     = control_reg[`TMR2_BIT_SPLIT];
  wire run       = control_reg[`TMR2_BIT_RUN];
  wire [1:0] sel = control_reg[`TMR2_SEL_MSB:`TMR2_SEL_LSB];

  wire wr_ctrl   = i_sfr_wr && (i_sfr_addr == `TMR2_ADDR_CONTROL);
  wire wr_rll    = i_sfr_wr && (i_sfr_addr == `TMR2_ADDR_RELOAD_LOW);

  wire rtc_rise;
  wire cmp_rise;
  wire div12_tick;
  wire rtc8_tick;
  wire low_tick;
  wire high_tick;

  // Slow sources are synchronised before any counting logic sees them
  tmr2_sync #(
    .STAGES(3)
  ) i_rtc_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst    (i_rst),
    .i_async  (i_rtc_clk),
    .o_rise   (rtc_rise)
  );

  tmr2_sync #(
    .STAGES(3)
  ) i_cmp_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst    (i_rst),
    .i_async  (i_comparator0),
    .o_rise   (cmp_rise)
  );

  // Alternate count sources
  tmr2_prescale #(
    .WIDTH(4),
    .LAST (`TMR2_CORE_CLOCK_DIV - 4'd1)
  ) i_div12 (
    .i_sys_clk(i_sys_clk),
    .i_rst    (i_rst),
    .i_step   (1'b1),
    .o_tick   (div12_tick)
  );

  tmr2_prescale #(
    .WIDTH(3),
    .LAST (`TMR2_RTC_DIV)
  ) i_rtc_div (
    .i_sys_clk(i_sys_clk),
    .i_rst    (i_rst),
    .i_step   (rtc_rise),
    .o_tick   (rtc8_tick)
  );

  wire alt_tick  = (sel == `TMR2_SEL_RTC_CLOCK) ? rtc8_tick : div12_tick;
  wire cap_trig  = sel[1] ? cmp_rise : rtc8_tick;

  // Each byte picks the core clock or the alternate tick
  tmr2_clock_pick i_low_pick (
    .i_core_clock_select(i_low_byte_core_clock_select),
    .i_alt_tick     (alt_tick),
    .o_tick         (low_tick)
  );

  tmr2_clock_pick i_high_pick (
    .i_core_clock_select(i_high_byte_core_clock_select),
    .i_alt_tick     (alt_tick),
    .o_tick         (high_tick)
  );

  wire cap_event = capture && cap_trig;

  // Counting conditions per mode
  wire low_en    = split ? low_tick : (run && low_tick);
  wire high_en   = split ? (run && high_tick) : (low_en && o_count_low_byte == 8'hff);
  wire low_wrap  = low_en && (o_count_low_byte == 8'hff);
  wire high_wrap = high_en && (o_count_high_byte == 8'hff);
  wire full_reload = !split && high_wrap && !capture;
  wire [7:0] low_count_plus  = o_count_low_byte + 8'd1;
  wire [7:0] high_count_plus = o_count_high_byte + 8'd1;

  // Flag set requests from the counter and the capture path
  wire set_high_flag = high_wrap || cap_event;
  wire set_low_flag  = low_wrap;

  // Next count for both bytes; a full 16-bit wrap with capture off reloads both at once
  always @* begin
    low_count_next  = o_count_low_byte;
    high_count_next = o_count_high_byte;
    if (full_reload) begin
      low_count_next  = reload_low_reg;
      high_count_next = i_reload_high_byte;
    end else begin
      if (low_en) begin
        if (split && low_wrap)
          low_count_next = reload_low_reg;
        else
          low_count_next = low_count_plus;
      end

      if (high_en) begin
        if (split && high_wrap)
          high_count_next = i_reload_high_byte;
        else
          high_count_next = high_count_plus;
      end
    end
  end

  // A capture overrides a software write to the low reload byte
  always @* begin
    reload_low_next = reload_low_reg;
    if (cap_event)
      reload_low_next = o_count_low_byte;
    else if (wr_rll)
      reload_low_next = i_sfr_wdata;
  end

  // Hardware sets win over a software clear in the same cycle
  always @* begin
    control_next = control_reg;
    if (wr_ctrl) begin
      control_next = i_sfr_wdata;
    end
    if (set_high_flag) begin
      control_next[`TMR2_BIT_HIGH_FLAG] = 1'b1;
    end
    if (set_low_flag) begin
      control_next[`TMR2_BIT_LOW_FLAG] = 1'b1;
    end
  end

  // Registers, counters and capture outputs
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      control_reg         <= `TMR2_RST_CONTROL;
      reload_low_reg      <= `TMR2_RST_RELOAD_LOW;
      o_count_low_byte    <= 8'h00;
      o_count_high_byte   <= 8'h00;
      o_capture_load      <= 1'b0;
      o_capture_high_byte <= 8'h00;
    end else begin
      control_reg    <= control_next;
      o_capture_load <= cap_event;
      reload_low_reg <= reload_low_next;
      if (cap_event) begin
        o_capture_high_byte <= o_count_high_byte;
      end
      o_count_low_byte  <= low_count_next;
      o_count_high_byte <= high_count_next;
    end
  end

  always @* begin
    o_sfr_rdata = 8'h00;
    case (i_sfr_addr)
      `TMR2_ADDR_CONTROL: begin
        o_sfr_rdata = control_reg;
      end
      `TMR2_ADDR_RELOAD_LOW: begin
        o_sfr_rdata = reload_low_reg;
      end
      default: begin
        o_sfr_rdata = 8'h00;
      end
    endcase
  end

  // High flag always requests; low flag only with its own enable
  wire irq_from_high = high_flag;
  wire irq_from_low  = low_irqen && low_flag;
  assign o_timer_irq = i_timer_irq_enable && (irq_from_high || irq_from_low);

endmodule // tmr2_control

// Two flip-flop synchroniser with an edge stage behind it
module tmr2_sync #(
  parameter STAGES = 3
) (
  input  wire i_sys_clk,
  input  wire i_rst,
  input  wire i_async,
  output wire o_rise
);

  reg  [STAGES-1:0] sync_reg;
  wire [STAGES-1:0] sync_next;

  // Only the second stage onward is read by logic
  assign sync_next = {sync_reg[STAGES-2:0], i_async};
  assign o_rise    = sync_reg[STAGES-2] & ~sync_reg[STAGES-1];

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync_reg <= {STAGES{1'b0}};
    end else begin
      sync_reg <= sync_next;
    end
  end

endmodule // tmr2_sync

// Divider that ticks once every LAST plus one steps
module tmr2_prescale #(
  parameter             WIDTH = 4,
  parameter [WIDTH-1:0] LAST  = `TMR2_CORE_CLOCK_DIV - 4'd1
) (
  input  wire i_sys_clk,
  input  wire i_rst,
  input  wire i_step,
  output wire o_tick
);

  reg  [WIDTH-1:0] count_reg;
  reg  [WIDTH-1:0] count_next;

  assign o_tick = i_step && (count_reg == LAST);

  // Terminal count restarts the divider
  always @* begin
    count_next = count_reg;
    if (o_tick) begin
      count_next = {WIDTH{1'b0}};
    end else if (i_step) begin
      count_next = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= {WIDTH{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

endmodule // tmr2_prescale

// Per-byte choice between the full core clock and the alternate tick
module tmr2_clock_pick (
  input  wire i_core_clock_select,
  input  wire i_alt_tick,
  output wire o_tick
);

  assign o_tick = i_core_clock_select ? 1'b1 : i_alt_tick;

endmodule // tmr2_clock_pick

// file: tmr2_control_assertions.sv
// Port-level property checker for the timer control block
`timescale 1ns/1ps
module tmr2_checker (
  input wire       i_sys_clk, i_rst, i_sfr_wr, i_timer_irq_enable, i_low_byte_core_clock_select,
  input wire       o_timer_irq,
  input wire [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, i_reload_high_byte, o_count_low_byte,
  input wire [7:0] o_count_high_byte
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire       a = i_sfr_addr == 8'hc8;
  wire [7:0] r = o_sfr_rdata, h = o_count_high_byte, l = o_count_low_byte;
  property p_irq; a |-> o_timer_irq == (i_timer_irq_enable & (r[7] | r[5] & r[6])); endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_hi; a && $past(h) == 8'hff && h != 8'hff |-> r[7]; endproperty
  a_hi: assert property (p_hi) else $error("high flag missing");
  property p_lo; a && $past(l) == 8'hff && l != 8'hff |-> r[6]; endproperty
  a_lo: assert property (p_lo) else $error("low flag missing");
  property p_rld; $past(a && r[4:3] == 0) && $past({h, l}) == 16'hffff && h != 8'hff
    |-> h == $past(i_reload_high_byte); endproperty
  a_rld: assert property (p_rld) else $error("reload wrong");
  property p_run; a && !i_sfr_wr && r[3:2] == 0 |=> $stable({h, l}); endproperty
  a_run: assert property (p_run) else $error("count while stopped");
  property p_spl; a && !i_sfr_wr && r[3:2] == 2 |=> $stable(h); endproperty
  a_spl: assert property (p_spl) else $error("high byte ran");
  property p_free; a && !i_sfr_wr && r[3] && i_low_byte_core_clock_select && l != 8'hff
    |=> l == $past(l) + 8'h01; endproperty
  a_free: assert property (p_free) else $error("low byte stalled");
  property p_rll; i_sfr_wr && i_sfr_addr == 8'hca ##1 i_sfr_addr == 8'hca |-> r == $past(i_sfr_wdata); endproperty
  a_rll: assert property (p_rll) else $error("reload low readback");
endmodule // tmr2_checker
bind tmr2_control tmr2_checker i_chk (.*);

// file: testbench.sv
// Self-checking bench for the timer control block
`timescale 1ns/1ps
module testbench;
  reg        clk = 0, rst = 1, wr = 0, rtc = 0, lsel = 1, hsel = 1, cmp = 0, ien = 1;
  reg  [7:0] ad = 8'hc8, wd = 8'h00, v;
  wire [7:0] rd, cl, ch, chb;
  wire       irq, cap;
  integer    err_total = 0, comparisons = 0, n;
  tmr2_control i_dut (.i_sys_clk(clk), .i_rst(rst), .i_sfr_addr(ad), .i_sfr_wdata(wd),
    .i_sfr_wr(wr), .o_sfr_rdata(rd), .i_timer_irq_enable(ien),
    .i_high_byte_core_clock_select(hsel), .i_low_byte_core_clock_select(lsel),
    .i_reload_high_byte(8'hfe), .i_rtc_clk(rtc), .i_comparator0(cmp),
    .o_count_low_byte(cl), .o_count_high_byte(ch), .o_capture_load(cap),
    .o_capture_high_byte(chb), .o_timer_irq(irq));
  initial forever #2 clk = ~clk;
  always #20 rtc = ~rtc;
  task test_done;
    begin
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] s, e, input string m);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("mismatch %s expected %h seen %h", m, e, s);
      end
    end
  endtask
  task t(input b);
    if (!b) begin
      err_total = err_total + 1;
      test_done;
    end
  endtask
  task w(input [7:0] a, d);
    begin
      @(posedge clk) #1 {ad, wd, wr} = {a, d, 1'b1};
      @(posedge clk) #1 wr = 0;
    end
  endtask
  task gap(output integer g);
    begin
      v = cl;
      for (g = 0; g < 99 && cl == v; g = g + 1) @(posedge clk) #1;
      v = cl;
      for (g = 0; g < 99 && cl == v; g = g + 1) @(posedge clk) #1;
    end
  endtask
  task k(input [7:0] a, e);
    begin
      @(posedge clk) #1 ad = a;
      #1 chk(rd, e, "rdata");
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 0;
    k(8'hc8, 8'h00);
    k(8'hca, 8'h00);
    w(8'hc8, 8'h14);
    k(8'hc8, 8'h14);
    for (n = 0; n < 999 && !cap; n = n + 1) @(posedge clk) #1;
    t(cap);
    v = cl;
    chk(rd[7], 1, "capture flag");
    chk(chb, 8'h00, "capture high");
    k(8'hca, v - 8'd1);
    w(8'hc8, 8'h04);
    w(8'hca, 8'h5a);
    k(8'hca, 8'h5a);
    k(8'hcb, 8'h00);
    ad = 8'hc8;
    for (n = 0; n < 70000 && !rd[7]; n = n + 1) @(posedge clk) #1;
    t(rd[7]);
    chk({ch, cl}, 16'hfe5a, "count");
    chk(irq, 1, "irq");
    ien = 0;
    #1 chk(irq, 0, "irq gated");
    ien = 1;
    k(8'hc8, 8'hc4);
    w(8'hc8, 8'h24);
    k(8'hc8, 8'h24);
    for (n = 0; n < 300 && !rd[6]; n = n + 1) @(posedge clk) #1;
    t(rd[6]);
    chk({irq, rd}, 16'h0164, "irq");
    w(8'hc8, 8'h08);
    k(8'hc8, 8'h08);
    for (n = 0; n < 300 && cl != 8'hff; n = n + 1) @(posedge clk) #1;
    t(cl == 8'hff);
    @(posedge clk) #1 chk(cl, 8'h5a, "low byte");
    chk(ch, 8'hff, "high byte");
    lsel = 0;
    w(8'hc8, 8'h04);
    gap(n);
    chk(n, 12, "div12 period");
    w(8'hc8, 8'h07);
    gap(n);
    chk(n, 80, "rtc8 period");
    w(8'hc8, 8'h16);
    for (n = 0; n < 99 && !cap; n = n + 1) @(posedge clk) #1;
    chk(cap, 0, "no rtc capture");
    cmp = 1;
    for (n = 0; n < 9 && !cap; n = n + 1) @(posedge clk) #1;
    chk({cap, rd[7]}, 2'h3, "cmp capture");
    test_done;
  end
endmodule // testbench
